//--- psg_group_chk.sv
// Checker for the phase share group block, watching its ports only.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps

module psg_group_chk #(
  parameter int CUR_W = 12
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  cmd_code,
  input wire logic        cmd_wr,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic        cmd_hit,
  input wire logic        restart_cfg,
  input wire logic        onoff_from_bus,
  input wire logic        local_fault,
  input wire logic [CUR_W-1:0] local_current,
  input wire logic [CUR_W-1:0] share_current_tx,
  input wire logic        bcast_enable_tx,
  input wire logic        fault_tx,
  input wire logic        is_master,
  input wire logic        stage_running,
  input wire logic        group_restart,
  input wire logic        min_duty_clamp,
  input wire logic [8:0]  min_duty_divisor,
  input wire logic        sync_pin_oe,
  input wire logic        sync_clk_sel
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  a_write_readback: assert property (cmd_wr && cmd_hit |=>
    (!$stable(cmd_code) || cmd_rdata == $past(cmd_wdata))) else $error("readback differs");
  a_unknown_zero: assert property (!cmd_hit |-> cmd_rdata == 16'h0000)
    else $error("unknown code reads nonzero");

  ////////////////////////////////////////////////////////////////////////////
  // Group role, fault and restart
  a_share_tx: assert property (rst_n |=> share_current_tx == $past(local_current))
    else $error("share figure not sent");
  a_restart_pulse: assert property (group_restart |=> !group_restart)
    else $error("restart pulse too long");
  a_restart_cause: assert property (group_restart |->
    $past(restart_cfg) && !$past(stage_running)) else $error("restart without cause");
  // Without restart the dropped stage must have lost the master role three cycles after the fault
  a_drop_no_master: assert property (stage_running && local_fault && !restart_cfg |=>
    !stage_running ##2 !is_master) else $error("dropped stage still leads");
  a_fault_pulse: assert property (fault_tx |=> !fault_tx)
    else $error("fault spread held");

  ////////////////////////////////////////////////////////////////////////////
  // Broadcast, duty clamp and phase clock pin
  a_bcast_gate: assert property (rst_n && !onoff_from_bus |=> !bcast_enable_tx)
    else $error("enable relayed under pin control");
  a_min_duty: assert property (min_duty_clamp |-> min_duty_divisor == 9'h100)
    else $error("wrong duty divisor");
  a_sync_dir: assert property (sync_pin_oe |-> !sync_clk_sel)
    else $error("pin drives and listens");
endmodule

bind psg_phase_share_group psg_group_chk #(.CUR_W(CUR_W)) i_psg_group_chk (.*);

//--- psg_peer_model.sv
// Behavioural model of the other stages on the shared group bus.
// Assumes the testbench commands peer status by position and broadcasts by group number.
`timescale 1ns/100ps

module psg_peer_model (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  alive_cmd,
  input wire logic [7:0]  down_cmd,
  input wire logic [11:0] master_current,
  input wire logic        peer_en,
  input wire logic        peer_mg,
  input wire logic [4:0]  peer_grp,
  output logic [7:0]      peer_alive,
  output logic [7:0]      peer_down,
  output logic [11:0]     share_current_rx,
  output logic            bcast_enable_rx,
  output logic            bcast_margin_rx,
  output logic [4:0]      bcast_group_rx
);
  ////////////////////////////////////////////////////////////////////////////
  // Peer status one cycle after command; survivors keep running
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      peer_alive <= 8'h00;
      peer_down  <= 8'h00;
    end else begin
      peer_alive <= alive_cmd;
      peer_down  <= down_cmd;
    end
  end

  // Peer master sends its figure; released bus toggles so no stale value
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      share_current_rx <= 12'h000;
    end else if (alive_cmd[0]) begin
      share_current_rx <= master_current;
    end else begin
      share_current_rx <= ~share_current_rx;
    end
  end

  // Relayed broadcasts carry the sender's group number
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bcast_enable_rx <= 1'b0;
      bcast_margin_rx <= 1'b0;
      bcast_group_rx  <= 5'h00;
    end else begin
      bcast_enable_rx <= peer_en;
      bcast_margin_rx <= peer_mg;
      bcast_group_rx  <= peer_grp;
    end
  end
endmodule

//--- psg_phase_share_group.sv
// Configuration and group-role logic of one power stage in a sharing group.
// Assumes peers report live/down status by position over the group bus and
// that all stages see the same bus view in the same cycle.
`timescale 1ns/100ps

module psg_phase_share_group #(
  parameter int MAX_POS = 8,
  parameter int CUR_W   = 12
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Management command port
  input  wire logic [7:0]       cmd_code,
  input  wire logic             cmd_wr,
  input  wire logic [15:0]      cmd_wdata,
  output logic [15:0]           cmd_rdata,
  output logic                  cmd_hit,
  // Local stage status
  input  wire logic             run_request,
  input  wire logic             local_fault,
  input  wire logic             restart_cfg,
  input  wire logic             onoff_from_bus,
  input  wire logic             bus_enable_cmd,
  input  wire logic             bus_margin_cmd,
  input  wire logic [CUR_W-1:0] local_current,
  // Group bus, peer view indexed by position
  input  wire logic [MAX_POS-1:0] peer_alive,
  input  wire logic [MAX_POS-1:0] peer_down,
  input  wire logic [CUR_W-1:0] share_current_rx,
  input  wire logic             bcast_enable_rx,
  input  wire logic             bcast_margin_rx,
  input  wire logic [4:0]       bcast_group_rx,
  output logic [CUR_W-1:0]      share_current_tx,
  output logic                  share_current_tx_valid,
  output logic                  bcast_enable_tx,
  output logic                  bcast_margin_tx,
  output logic [4:0]            bcast_group_tx,
  output logic                  fault_tx,
  output logic [4:0]            fault_rail_tx,
  // Stage controls
  output logic                  is_master,
  output logic [2:0]            master_pos,
  output logic                  stage_running,
  output logic                  group_restart,
  output logic [CUR_W-1:0]      share_reference,
  output logic                  group_enable,
  output logic                  group_margin,
  output logic                  min_duty_clamp,
  output logic [8:0]            min_duty_divisor,
  output logic                  monitor_active,
  output logic [4:0]            blank_cycles,
  output logic                  alt_ramp,
  // Phase clock pin
  input  wire logic             own_phase_clk,
  input  wire logic             sync_pin_i,
  output logic                  sync_pin_o,
  output logic                  sync_pin_oe,
  output logic                  sync_clk_sel
);

  // Elaboration checks; the position field is only three bits wide
  if (MAX_POS != 8) begin : g_bad_pos
    $error("MAX_POS must match the 3-bit position field");
  end
  if (CUR_W < 1) begin : g_bad_cur
    $error("CUR_W must be positive");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Setup registers

  logic [15:0] rail_bus_setup;
  logic [15:0] load_share_setup;
  logic [15:0] phase_user_setup;
  logic [15:0] maker_setup;
  logic [15:0] extra_setup;

  // Blanking ns to clock cycles, rounded up so no edge slips through
  function automatic logic [4:0] ns_to_cycles(input logic [4:0] ns);
    int c;
    c = (int'(ns) + psg_pkg::CLK_PERIOD_NS - 1) / psg_pkg::CLK_PERIOD_NS;
    return c[4:0];
  endfunction

  // Whole-word stores; reserved bits kept as written, no effect
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rail_bus_setup   <= psg_pkg::RST_RAIL_BUS;
      load_share_setup <= psg_pkg::RST_LOAD_SHARE;
      phase_user_setup <= psg_pkg::RST_USER;
      maker_setup      <= psg_pkg::RST_MAKER;
      extra_setup      <= psg_pkg::RST_EXTRA;
    end else if (cmd_wr) begin
      unique case (cmd_code)
        psg_pkg::CMD_RAIL_BUS:   rail_bus_setup   <= cmd_wdata;
        psg_pkg::CMD_LOAD_SHARE: load_share_setup <= cmd_wdata;
        psg_pkg::CMD_USER:       phase_user_setup <= cmd_wdata;
        psg_pkg::CMD_MAKER:      maker_setup      <= cmd_wdata;
        psg_pkg::CMD_EXTRA:      extra_setup      <= cmd_wdata;
        default: ;
      endcase
    end
  end

  // Readback; unknown codes answer zero with no hit
  always_comb begin
    cmd_hit   = 1'b1;
    cmd_rdata = 16'h0000;
    unique case (cmd_code)
      psg_pkg::CMD_RAIL_BUS:   cmd_rdata = rail_bus_setup;
      psg_pkg::CMD_LOAD_SHARE: cmd_rdata = load_share_setup;
      psg_pkg::CMD_USER:       cmd_rdata = phase_user_setup;
      psg_pkg::CMD_MAKER:      cmd_rdata = maker_setup;
      psg_pkg::CMD_EXTRA:      cmd_rdata = extra_setup;
      default:                 cmd_hit   = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Field decode

  logic [4:0] bc_group;
  logic [4:0] rail_id;
  logic       tx_inhibit;
  logic [2:0] member_cnt;
  logic [2:0] own_pos;
  logic       share_en;
  logic       fault_spread;
  logic       sync_in_only;
  logic       sync_out_en;
  logic       bc_margin_en;
  logic       bc_enable_en;

  assign bc_group     = rail_bus_setup[psg_pkg::RB_GROUP_LSB +: 5];
  assign rail_id      = rail_bus_setup[psg_pkg::RB_RAIL_LSB +: 5];
  assign tx_inhibit   = rail_bus_setup[psg_pkg::RB_TX_INH];
  assign member_cnt   = load_share_setup[psg_pkg::LS_COUNT_LSB +: 3];
  assign own_pos      = load_share_setup[psg_pkg::LS_POS_LSB +: 3];
  assign share_en     = load_share_setup[psg_pkg::LS_SHARE_EN];
  assign fault_spread = phase_user_setup[psg_pkg::US_FAULT_SPRD];
  assign sync_in_only = phase_user_setup[psg_pkg::US_SYNC_IN];
  assign sync_out_en  = phase_user_setup[psg_pkg::US_SYNC_OUT];
  assign bc_margin_en = extra_setup[psg_pkg::EX_BC_MARGIN];
  // Broadcast enable is meaningless with pin on/off control
  assign bc_enable_en = extra_setup[psg_pkg::EX_BC_ENABLE] & onoff_from_bus;

  //////////////////////////////////////////////////////////////////////////////
  // Stage lifecycle

  psg_pkg::psg_state_t state;
  psg_pkg::psg_state_t next_state;
  logic                all_down;
  logic                next_restart;

  // Every configured member down, this stage included
  always_comb begin
    all_down = 1'b1;
    for (int i = 0; i < MAX_POS; i++) begin
      if (i <= int'(member_cnt)) begin
        if (i == int'(own_pos)) begin
          all_down = all_down & (state == psg_pkg::PSG_DROPPED);
        end else begin
          all_down = all_down & peer_down[i];
        end
      end
    end
  end

  // One synchronized restart only when the whole group is down
  assign next_restart = restart_cfg & all_down & share_en;

  always_comb begin
    next_state = state;
    unique case (state)
      psg_pkg::PSG_IDLE: begin
        if (local_fault) begin
          next_state = psg_pkg::PSG_DROPPED;
        end else if (run_request) begin
          next_state = psg_pkg::PSG_RUN;
        end
      end
      psg_pkg::PSG_RUN: begin
        if (local_fault) begin
          next_state = psg_pkg::PSG_DROPPED;
        end else if (!run_request) begin
          next_state = psg_pkg::PSG_IDLE;
        end
      end
      psg_pkg::PSG_DROPPED: begin
        // No way back but the group restart
        if (next_restart) begin
          next_state = psg_pkg::PSG_IDLE;
        end
      end
      default: next_state = psg_pkg::PSG_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= psg_pkg::PSG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Restart pulse, one cycle per whole-group shutdown
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      group_restart <= 1'b0;
    end else begin
      group_restart <= next_restart & (state == psg_pkg::PSG_DROPPED);
    end
  end

  assign stage_running = (state == psg_pkg::PSG_RUN);

  //////////////////////////////////////////////////////////////////////////////
  // Master election

  logic [2:0] next_master_pos;
  logic       found;

  // Lowest live position wins; a dropped member is skipped
  always_comb begin
    next_master_pos = own_pos;
    found           = 1'b0;
    for (int i = 0; i < MAX_POS; i++) begin
      if (!found && i <= int'(member_cnt)) begin
        if (i == int'(own_pos) ? (state != psg_pkg::PSG_DROPPED) : peer_alive[i]) begin
          next_master_pos = 3'(i);
          found           = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      master_pos <= 3'h0;
      is_master  <= 1'b0;
    end else begin
      master_pos <= next_master_pos;
      is_master  <= share_en & found & (next_master_pos == own_pos)
                    & (state != psg_pkg::PSG_DROPPED);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Group bus transmit and receive

  // Master publishes its current; slaves track the received figure
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      share_current_tx       <= '0;
      share_current_tx_valid <= 1'b0;
      share_reference        <= '0;
    end else begin
      share_current_tx       <= local_current;
      share_current_tx_valid <= is_master & stage_running & !tx_inhibit;
      share_reference        <= is_master ? local_current : share_current_rx;
    end
  end

  // Relay local bus enable and margin to the broadcast group
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bcast_enable_tx <= 1'b0;
      bcast_margin_tx <= 1'b0;
      bcast_group_tx  <= 5'h00;
      fault_tx        <= 1'b0;
      fault_rail_tx   <= 5'h00;
    end else begin
      bcast_enable_tx <= bus_enable_cmd & bc_enable_en & !tx_inhibit;
      bcast_margin_tx <= bus_margin_cmd & bc_margin_en & !tx_inhibit;
      bcast_group_tx  <= bc_group;
      // Fault spreading only on the fault's first cycle
      fault_tx        <= fault_spread & !tx_inhibit & local_fault
                         & (state != psg_pkg::PSG_DROPPED);
      fault_rail_tx   <= rail_id;
    end
  end

  // Enable and margin as seen by this stage, local or from its group
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      group_enable <= 1'b0;
      group_margin <= 1'b0;
    end else begin
      group_enable <= (bus_enable_cmd & onoff_from_bus)
                      | (bcast_enable_rx & bc_enable_en & (bcast_group_rx == bc_group));
      group_margin <= bus_margin_cmd
                      | (bcast_margin_rx & bc_margin_en & (bcast_group_rx == bc_group));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Stage controls from the user and maker setup

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      min_duty_clamp   <= 1'b0;
      min_duty_divisor <= 9'h000;
      monitor_active   <= 1'b0;
      blank_cycles     <= 5'h00;
      alt_ramp         <= 1'b0;
    end else begin
      min_duty_clamp   <= phase_user_setup[psg_pkg::US_MINDUTY_LSB +: 3]
                          == psg_pkg::MINDUTY_DIV256;
      min_duty_divisor <= 9'(psg_pkg::MINDUTY_DIVISOR);
      monitor_active   <= phase_user_setup[psg_pkg::US_STBY_LSB +: 2]
                          == psg_pkg::STBY_MONITOR;
      blank_cycles     <= ns_to_cycles(maker_setup[psg_pkg::MK_BLANK_LSB +: 5]);
      alt_ramp         <= maker_setup[psg_pkg::MK_ALT_RAMP];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Phase clock pin

  logic drive_sync;

  // Input-only wins over output request, so a misconfigured slave never fights
  assign drive_sync = sync_out_en & !sync_in_only;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync_pin_o   <= 1'b0;
      sync_pin_oe  <= 1'b0;
      sync_clk_sel <= 1'b0;
    end else begin
      sync_pin_o   <= own_phase_clk;
      // Open drain only pulls low; push-pull drives both levels
      sync_pin_oe  <= drive_sync
                      & (maker_setup[psg_pkg::MK_PUSHPULL] | !own_phase_clk);
      sync_clk_sel <= !drive_sync & sync_pin_i;
    end
  end

endmodule

//--- psg_phase_share_group_test.sv
// Self-checking testbench for the phase share group block.
// Assumes the package command codes and reset values; peers come from the model.
`timescale 1ns/100ps

module psg_phase_share_group_test;
  logic core_clk = 1'b0, rst_n = 1'b0, cmd_wr = 1'b0, run_request = 1'b0;
  logic local_fault = 1'b0, restart_cfg = 1'b0, onoff_from_bus = 1'b0;
  logic bus_enable_cmd = 1'b0, bus_margin_cmd = 1'b0, own_phase_clk = 1'b0;
  logic ext_sync = 1'b1, peer_en = 1'b0, peer_mg = 1'b0;
  logic [7:0] cmd_code = 8'h00, alive_cmd = 8'h00, down_cmd = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [11:0] local_current = 12'hA5C, master_current = 12'h3C1;
  logic [4:0] peer_grp = 5'h00;
  logic [7:0] peer_alive, peer_down;
  logic [11:0] share_current_rx, share_current_tx, share_reference;
  logic [4:0] bcast_group_rx, bcast_group_tx, fault_rail_tx, blank_cycles;
  logic [15:0] cmd_rdata;
  logic [2:0] master_pos;
  logic [8:0] min_duty_divisor;
  logic bcast_enable_rx, bcast_margin_rx, cmd_hit, share_current_tx_valid, bcast_enable_tx;
  logic bcast_margin_tx, fault_tx, is_master, stage_running, group_restart, group_enable;
  logic group_margin, min_duty_clamp, monitor_active, alt_ramp, sync_pin_o, sync_pin_oe;
  logic sync_clk_sel, sync_pin_i;
  int fail_count = 0;
  int check_count = 0;

  // Pin level: our drive wins, else the other source
  assign sync_pin_i = sync_pin_oe ? sync_pin_o : ext_sync;
  always #5 core_clk = ~core_clk;

  psg_phase_share_group i_psg_phase_share_group (.*);
  psg_peer_model i_psg_peer_model (.*);

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic settle;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge core_clk);
    cmd_code <= code;
    cmd_wdata <= data;
    cmd_wr <= 1'b1;
    @(posedge core_clk);
    cmd_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    @(posedge core_clk);
    cmd_code <= code;
    #1;
    chk("cmd_rdata", exp, cmd_rdata);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs;
    logic [15:0] rv [5];
    rv = '{psg_pkg::RST_RAIL_BUS, psg_pkg::RST_LOAD_SHARE, psg_pkg::RST_USER,
           psg_pkg::RST_MAKER, psg_pkg::RST_EXTRA};
    for (int i = 0; i < 5; i++) begin
      rd(8'hE0 + 8'(i), rv[i]);
      wr(8'hE0 + 8'(i), 16'hC35A ^ 16'(i));
      rd(8'hE0 + 8'(i), 16'hC35A ^ 16'(i));
    end
    wr(8'hE5, 16'hFFFF);
    rd(8'hE5, 16'h0000);
    chk("cmd_hit", 1'b0, cmd_hit);
    wr(psg_pkg::CMD_RAIL_BUS, 16'h0407);
    settle;
    chk("bcast_group_tx", 5'h04, bcast_group_tx);
    chk("fault_rail_tx", 5'h07, fault_rail_tx);
    // Pattern writes left standby at 00, min duty at 110, alt ramp off
    chk("monitor_active", 1'b0, monitor_active);
    chk("min_duty_clamp", 1'b0, min_duty_clamp);
    chk("alt_ramp", 1'b0, alt_ramp);
  endtask

  task automatic t_role;
    // Sharing on at position 0, count field 1; the upper byte 07 is not decoded
    wr(psg_pkg::CMD_LOAD_SHARE, 16'h0721);
    alive_cmd <= 8'h02;
    settle;
    chk("is_master", 1'b1, is_master);
    chk("share_reference", local_current, share_reference);
    chk("share_current_tx_valid", 1'b0, share_current_tx_valid);
    wr(psg_pkg::CMD_LOAD_SHARE, 16'h0725);
    alive_cmd <= 8'h01;
    settle;
    chk("master_pos", 3'h0, master_pos);
    chk("is_master", 1'b0, is_master);
    chk("share_reference", master_current, share_reference);
    chk("share_current_tx", local_current, share_current_tx);
    @(posedge core_clk);
    alive_cmd <= 8'h00;
    settle;
    chk("master_pos", 3'h1, master_pos);
    chk("is_master", 1'b1, is_master);
  endtask

  task automatic t_fault;
    int n;
    wr(psg_pkg::CMD_USER, 16'h2151);
    run_request <= 1'b1;
    settle;
    chk("stage_running", 1'b1, stage_running);
    @(posedge core_clk);
    local_fault <= 1'b1;
    @(posedge core_clk);
    local_fault <= 1'b0;
    #1;
    chk("fault_tx", 1'b1, fault_tx);
    @(posedge core_clk);
    restart_cfg <= 1'b1;
    settle;
    chk("stage_running", 1'b0, stage_running);
    chk("is_master", 1'b0, is_master);
    chk("group_restart", 1'b0, group_restart);
    @(posedge core_clk);
    down_cmd <= 8'h01;
    n = 0;
    while (group_restart !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("group_restart", 1'b1, group_restart);
    @(posedge core_clk);
    down_cmd <= 8'h00;
    restart_cfg <= 1'b0;
    settle;
    chk("stage_running", 1'b1, stage_running);
    // Restarted stage leads again and publishes its figure
    chk("share_current_tx_valid", 1'b1, share_current_tx_valid);
  endtask

  task automatic t_bcast;
    wr(psg_pkg::CMD_EXTRA, 16'h4000);
    bus_enable_cmd <= 1'b1;
    settle;
    chk("bcast_enable_tx", 1'b0, bcast_enable_tx);
    @(posedge core_clk);
    onoff_from_bus <= 1'b1;
    settle;
    chk("bcast_enable_tx", 1'b1, bcast_enable_tx);
    wr(psg_pkg::CMD_RAIL_BUS, 16'h0427);
    settle;
    chk("bcast_enable_tx", 1'b0, bcast_enable_tx);
    wr(psg_pkg::CMD_RAIL_BUS, 16'h0407);
    bus_enable_cmd <= 1'b0;
    peer_en <= 1'b1;
    peer_grp <= 5'h04;
    settle;
    chk("group_enable", 1'b1, group_enable);
    @(posedge core_clk);
    peer_grp <= 5'h05;
    settle;
    chk("group_enable", 1'b0, group_enable);
    wr(psg_pkg::CMD_EXTRA, 16'hC000);
    bus_margin_cmd <= 1'b1;
    settle;
    chk("bcast_margin_tx", 1'b1, bcast_margin_tx);
    chk("group_margin", 1'b1, group_margin);
  endtask

  task automatic t_sync;
    wr(psg_pkg::CMD_USER, 16'h2031);
    // Push-pull pin, alternate ramp on and 17 ns blanking, which rounds up to 2 cycles
    wr(psg_pkg::CMD_MAKER, 16'h8F15);
    own_phase_clk <= 1'b1;
    settle;
    chk("sync_pin_oe", 1'b1, sync_pin_oe);
    chk("sync_pin_o", 1'b1, sync_pin_o);
    chk("min_duty_clamp", 1'b1, min_duty_clamp);
    chk("min_duty_divisor", 9'h100, min_duty_divisor);
    chk("monitor_active", 1'b1, monitor_active);
    wr(psg_pkg::CMD_MAKER, 16'h8F14);
    settle;
    chk("sync_pin_oe", 1'b0, sync_pin_oe);
    chk("blank_cycles", 5'h02, blank_cycles);
    chk("alt_ramp", 1'b1, alt_ramp);
    wr(psg_pkg::CMD_USER, 16'h2051);
    // Pull-up holds the undriven pin high, so input-only must listen to it
    ext_sync <= 1'b1;
    settle;
    chk("sync_pin_oe", 1'b0, sync_pin_oe);
    chk("sync_clk_sel", 1'b1, sync_clk_sel);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Run control
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs;
    t_role;
    t_fault;
    t_bcast;
    t_sync;
    finish_test;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    finish_test;
  end
endmodule

//--- psg_pkg.sv
// Constants for the phase share group configuration block: command codes,
// field positions, reset values and timing figures.
// Assumes a single 100 MHz controller clock and a byte-coded command port.
package psg_pkg;

  // Command codes on the management port
  localparam logic [7:0] CMD_RAIL_BUS   = 8'hE0;
  localparam logic [7:0] CMD_LOAD_SHARE = 8'hE1;
  localparam logic [7:0] CMD_USER       = 8'hE2;
  localparam logic [7:0] CMD_MAKER      = 8'hE3;
  localparam logic [7:0] CMD_EXTRA      = 8'hE4;

  // Reset values
  localparam logic [15:0] RST_RAIL_BUS   = 16'h0000;
  localparam logic [15:0] RST_LOAD_SHARE = 16'h0000;
  localparam logic [15:0] RST_USER       = 16'h0001;
  localparam logic [15:0] RST_MAKER      = 16'h0000;
  localparam logic [15:0] RST_EXTRA      = 16'h0000;

  // rail_bus_setup fields
  localparam int RB_GROUP_LSB = 8;
  localparam int RB_TX_INH    = 5;
  localparam int RB_RAIL_LSB  = 0;
  // load_share_setup fields
  localparam int LS_COUNT_LSB = 5;
  localparam int LS_POS_LSB   = 2;
  localparam int LS_SHARE_EN  = 0;
  // phase_user_setup fields
  localparam int US_MINDUTY_LSB = 13;
  localparam int US_FAULT_SPRD  = 8;
  localparam int US_SYNC_IN     = 6;
  localparam int US_SYNC_OUT    = 5;
  localparam int US_STBY_LSB    = 0;
  localparam logic [2:0] MINDUTY_DIV256 = 3'h1;
  localparam logic [1:0] STBY_MONITOR   = 2'h1;
  localparam int MINDUTY_DIVISOR = 256;
  // maker_setup fields
  localparam int MK_BLANK_LSB = 11;
  localparam int MK_ALT_RAMP  = 2;
  localparam int MK_PUSHPULL  = 0;
  // extra_setup fields
  localparam int EX_BC_MARGIN = 15;
  localparam int EX_BC_ENABLE = 14;

  // Timing
  localparam int CLK_PERIOD_NS = 10;

  typedef enum logic [2:0] {
    PSG_IDLE    = 3'b001,
    PSG_RUN     = 3'b010,
    PSG_DROPPED = 3'b100
  } psg_state_t;

endpackage
